// >>> dv/sca_chk.sv
`include "sca_cfg.svh"

module sca_chk #(
    parameter int unsigned CONV_CYC = `SCA_CONV_CYC,
    parameter int unsigned LEAD_CYC = `SCA_LEAD_CYC,
    parameter int unsigned REARM_CYC = `SCA_REARM_CYC
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Link signals.
    input wire logic cs_n,
    input wire logic rd_conv,
    input wire logic busy_n,
    input wire sca_pkg::sca_word_t result_bus,
    input wire logic result_oe
);
    logic [15:0] low_cnt_ff;
    logic [15:0] nxt_low_cnt;
    logic [15:0] high_cnt_ff;
    logic [15:0] nxt_high_cnt;

    // Counts the cycles for which busy has been sampled low, and high (saturating).
    assign nxt_low_cnt = busy_n ? 16'h0000 : low_cnt_ff + 16'h0001;
    assign nxt_high_cnt = !busy_n ? 16'h0000 :
        ((high_cnt_ff == 16'hFFFF) ? high_cnt_ff : high_cnt_ff + 16'h0001);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_ff <= 16'h0000;
            high_cnt_ff <= 16'h0000;
        end else begin
            low_cnt_ff <= nxt_low_cnt;
            high_cnt_ff <= nxt_high_cnt;
        end
    end

    // Timing of busy and of the bus against the selects.
    chk_start_busy: assert property (@(posedge clock) disable iff (!rst_n)
        (busy_n && !cs_n && !rd_conv && !$past(!cs_n && !rd_conv)) |=> !busy_n)
        else $error("busy did not fall after a start");
    chk_conv_len: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(busy_n) |-> low_cnt_ff == CONV_CYC)
        else $error("busy low time differs from the conversion time");
    chk_conv_max: assert property (@(posedge clock) disable iff (!rst_n)
        low_cnt_ff <= CONV_CYC)
        else $error("busy stayed low too long");
    chk_bus_off: assert property (@(posedge clock) disable iff (!rst_n)
        (!busy_n && result_oe) |-> low_cnt_ff >= CONV_CYC - LEAD_CYC)
        else $error("bus driven early in a conversion");
    chk_lead_time: assert property (@(posedge clock) disable iff (!rst_n)
        ($rose(busy_n) && result_oe) |-> $past(result_oe, LEAD_CYC))
        else $error("data not driven ahead of busy");
    chk_deselect_off: assert property (@(posedge clock) disable iff (!rst_n)
        (cs_n || !rd_conv) |=> !result_oe)
        else $error("bus driven while not read-selected");
    chk_idle_read: assert property (@(posedge clock) disable iff (!rst_n)
        (busy_n && !cs_n && rd_conv) |=> result_oe)
        else $error("idle read did not enable the bus");
    chk_bus_steady: assert property (@(posedge clock) disable iff (!rst_n)
        (result_oe && $past(result_oe)) |-> $stable(result_bus))
        else $error("driven result changed");
    chk_restart: assert property (@(posedge clock) disable iff (!rst_n)
        (busy_n && (high_cnt_ff == REARM_CYC - 1) && !cs_n && !rd_conv) |=> !busy_n)
        else $error("held start did not restart");
    chk_busy_hold: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(busy_n) |-> !busy_n [*8])
        else $error("busy pulse too short");
endmodule

// >>> dv/testbench.sv
`include "sca_cfg.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 40;
    localparam int LEAD = 3;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic start_req = 1'b0;
    logic ready, dvalid, hold_b, done_b;
    sca_pkg::sca_word_t data, expb, lowc = '0, smp_a = '0, smp_b = '0;
    sca_pkg::sca_word_t codes[4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
    logic [31:0] rng = 32'hFC57;
    int error_cnt = 0;
    int n_compared = 0;
    sca_link_if l_a();
    sca_link_if l_b();

    // Link a joins both ends; link b has the device alone, driven by the bench.
    sca_dev #(.CONV_CYC(CONV), .LEAD_CYC(LEAD)) i_sca_dev (.clock(clock), .rst_n(rst_n),
        .link(l_a), .sample_in(smp_a), .hold_ff(), .done_ff());
    sca_host #(.SETUP_CYC(4), .RAISE_CYC(8), .SPACE_CYC(80)) i_sca_host (.clock(clock),
        .rst_n(rst_n), .link(l_a), .start_req(start_req), .ready_ff(ready),
        .data_valid_ff(dvalid), .data_ff(data));
    sca_dev #(.CONV_CYC(CONV), .LEAD_CYC(LEAD)) i_sca_dev_b (.clock(clock), .rst_n(rst_n),
        .link(l_b), .sample_in(smp_b), .hold_ff(hold_b), .done_ff(done_b));
    sca_chk #(.CONV_CYC(CONV), .LEAD_CYC(LEAD)) i_sca_chk (.clock(clock), .rst_n(rst_n),
        .cs_n(l_a.cs_n), .rd_conv(l_a.rd_conv), .busy_n(l_a.busy_n),
        .result_bus(l_a.result_bus), .result_oe(l_a.result_oe));

    // Free-running 200 MHz clock.
    always #2.5 clock = ~clock;

    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction

    task cmp_w(input string what, input sca_pkg::sca_word_t exp, input sca_pkg::sca_word_t got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task cmp_b(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task final_report;
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Drives the selects of link b at a rising edge and holds them for n cycles.
    task drv(input logic cs, input logic rd, input int n);
        @(posedge clock);
        l_b.cs_n <= cs;
        l_b.rd_conv <= rd;
        repeat (n) @(negedge clock);
    endtask

    task wait_rise;
        for (int i = 0; i < 200 && l_b.busy_n !== 1'b1; i++) @(negedge clock);
    endtask

    // One host transfer; the sample stays put until the word comes back.
    task host_xfer(input sca_pkg::sca_word_t code);
        for (int i = 0; i < 300 && ready !== 1'b1; i++) @(negedge clock);
        @(posedge clock);
        smp_a <= code;
        start_req <= 1'b1;
        @(posedge clock);
        start_req <= 1'b0;
        for (int i = 0; i < 300 && dvalid !== 1'b1; i++) @(negedge clock);
        cmp_w("host_data", code, data);
    endtask

    // Starts a conversion on link b, then parks the selects until busy rises.
    task run_b(input logic cs2, input logic rd2, input logic poke);
        expb = sca_pkg::sca_word_t'(rnd());
        @(posedge clock);
        smp_b <= expb;
        drv(1'b1, 1'b0, 21);
        drv(1'b0, 1'b0, 2);
        if (poke) begin
            drv(1'b1, 1'b0, 1);
            drv(1'b0, 1'b0, 2);
        end
        drv(cs2, rd2, 1);
        wait_rise();
    endtask

    // Model of link b: hold follows busy, done marks the rise, busy spans CONV cycles.
    always @(negedge clock) begin
        if (rst_n) begin
            cmp_b("hold_mode", ~l_b.busy_n, hold_b);
            cmp_b("done_pulse", l_b.busy_n && lowc != 0, done_b);
            if (l_b.busy_n === 1'b1 && lowc != 0) cmp_w("busy_len", 16'(CONV), lowc);
            lowc = (l_b.busy_n === 1'b0) ? lowc + 16'h0001 : 16'h0000;
        end
    end

    // A hang counts as a mismatch.
    initial begin
        #30us;
        error_cnt++;
        final_report();
    end

    // Main sequence.
    initial begin
        l_b.cs_n = 1'b1;
        l_b.rd_conv = 1'b1;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            host_xfer(k < 4 ? codes[k] : sca_pkg::sca_word_t'(rnd()));
        end
        run_b(1'b0, 1'b1, 1'b0);
        cmp_b("oe_at_end", 1'b1, l_b.result_oe);
        cmp_w("bus_at_end", expb, l_b.result_bus);
        drv(1'b1, 1'b1, 2);
        cmp_b("oe_idle_off", 1'b0, l_b.result_oe);
        run_b(1'b1, 1'b1, 1'b0);
        cmp_b("oe_deselected", 1'b0, l_b.result_oe);
        drv(1'b0, 1'b1, 2);
        cmp_b("oe_late_read", 1'b1, l_b.result_oe);
        cmp_w("bus_late_read", expb, l_b.result_bus);
        run_b(1'b1, 1'b0, 1'b1);
        cmp_b("oe_convert_sel", 1'b0, l_b.result_oe);
        drv(1'b0, 1'b1, 2);
        cmp_w("bus_read_later", expb, l_b.result_bus);
        run_b(1'b0, 1'b0, 1'b0);
        repeat (`SCA_REARM_CYC - 1) @(negedge clock);
        cmp_b("restart_early", 1'b1, l_b.busy_n);
        repeat (2) @(negedge clock);
        cmp_b("restart_busy", 1'b0, l_b.busy_n);
        drv(1'b1, 1'b1, 1);
        wait_rise();
        cmp_b("oe_after_restart", 1'b0, l_b.result_oe);
        final_report();
    end
endmodule

// >>> rtl/sca_cfg.svh
`ifndef SCA_CFG_SVH
`define SCA_CFG_SVH

// Clock period of the shared clock in picoseconds (200 MHz).
`define SCA_CLK_PS 5000

// Timing figures in nanoseconds, as printed.
`define SCA_T_CONV_NS 3300
`define SCA_T_LEAD_NS 35
`define SCA_T_LEAD_MIN_NS 25
`define SCA_T_REARM_NS 250
`define SCA_T_SETUP_NS 100
`define SCA_T_RAISE_NS 200
`define SCA_T_SPACE_NS 4000

// Cycle counts derived from the figures; least times round up, longest round down.
`define SCA_CONV_CYC ((`SCA_T_CONV_NS * 1000) / `SCA_CLK_PS)
`define SCA_LEAD_CYC ((`SCA_T_LEAD_NS * 1000 + `SCA_CLK_PS - 1) / `SCA_CLK_PS)
`define SCA_REARM_CYC ((`SCA_T_REARM_NS * 1000) / `SCA_CLK_PS)
`define SCA_SETUP_CYC ((`SCA_T_SETUP_NS * 1000 + `SCA_CLK_PS - 1) / `SCA_CLK_PS)
`define SCA_RAISE_CYC ((`SCA_T_RAISE_NS * 1000) / `SCA_CLK_PS)
`define SCA_SPACE_CYC ((`SCA_T_SPACE_NS * 1000 + `SCA_CLK_PS - 1) / `SCA_CLK_PS)

// Two's complement code points.
`define SCA_CODE_POS_FULL 16'h7FFF
`define SCA_CODE_MID 16'h0000
`define SCA_CODE_NEG_FULL 16'h8000

`endif

// >>> rtl/sca_dev.sv
`include "sca_cfg.svh"

// Contract
// - Convert request falling edge holds and starts.
// - At completion drive all sixteen result lines.
// - After completion return to sample mode.
// - Controller spaces starts 4 us apart.
// - Converting: bus off, busy low 3.3 us.
// - Data valid at least 25 ns before busy.
// - Idle: drive bus when read high, select low.
// - Select pair decides start and bus drive.
// - Controller avoids select-first then convert start.
// - Select raised early keeps bus off at end.
// - Read later with read high, select low.
// - Both low 250 ns after busy restarts.
// - Read/convert low 100 ns before select low.
// - Controller raises a select within 200 ns.
// - Controller holds selects static late in conversion.
// - Busy rising edge may latch the result.
// - Results coded in two's complement.
// - Bus off if deselected, convert, or converting.
// - Busy low from start until completion.
module sca_dev #(
    parameter int unsigned CONV_CYC = `SCA_CONV_CYC,
    parameter int unsigned LEAD_CYC = `SCA_LEAD_CYC
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Link to the controller.
    sca_link_if.dev link,
    // Sampled analog value as a signed code.
    input wire logic signed [sca_pkg::RES_W-1:0] sample_in,
    // Sample and hold mode, high while holding.
    output logic hold_ff,
    // Pulse when a conversion result is ready.
    output logic done_ff
);
    // Counter wide enough for the whole conversion time.
    localparam int unsigned CNT_W = $clog2(CONV_CYC + 1);
    // Restart window after busy rises, in clock cycles.
    localparam int unsigned REARM_CYC = `SCA_REARM_CYC;
    localparam int unsigned RW = $clog2(REARM_CYC + 1);

    // Refuse counts that the sequence cannot serve.
    initial begin
        if (LEAD_CYC < 1 || LEAD_CYC >= CONV_CYC) begin
            $error("sca_dev: lead must be at least one cycle and below the conversion time");
        end
        if (REARM_CYC < 1) begin
            $error("sca_dev: restart window must be at least one cycle");
        end
    end

    // Sequence state and conversion counter.
    sca_pkg::sca_dev_e state_ff;
    sca_pkg::sca_dev_e nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    // Link-side registers.
    logic req_ff;
    logic busy_n_ff;
    logic oe_ff;
    logic drive_ok_ff;
    // Captured sample and presented result.
    sca_pkg::sca_word_t result_ff;
    sca_pkg::sca_word_t held_ff;
    // Restart window counter.
    logic [RW-1:0] rearm_ff;
    logic [RW-1:0] nxt_rearm;

    // Conversion idle, that is, the sample and hold is acquiring.
    wire idle = (state_ff == sca_pkg::SCA_ACQ);
    // Restart window: a start level still present when it closes restarts the converter.
    wire rearm_hit = idle & (rearm_ff == RW'(1));
    // Start request: both selects low; its rising edge is the later of the two select falling edges.
    wire start_lvl = ~link.cs_n & ~link.rd_conv;
    wire start_edge = start_lvl & (~req_ff | rearm_hit);
    wire start_ok = start_edge & idle;
    wire read_sel = ~link.cs_n & link.rd_conv;
    wire deselect = link.cs_n;
    // The lead window opens with LEAD_CYC cycles of the conversion left.
    wire lead_start = (state_ff == sca_pkg::SCA_CONV) && (cnt_ff == CNT_W'(LEAD_CYC + 1));
    wire conv_end = (state_ff == sca_pkg::SCA_LEAD) && (cnt_ff == CNT_W'(1));

    // Next-state decodes, so that the bus enable switches together with the state.
    wire nxt_idle = (nxt_state == sca_pkg::SCA_ACQ);
    wire nxt_lead = (nxt_state == sca_pkg::SCA_LEAD);
    // Bus is allowed only when not converting or during the final lead window.
    wire bus_en = read_sel & (nxt_idle | nxt_lead);
    // In the lead window the bus is driven only if no deselect happened in the conversion.
    wire nxt_oe = nxt_idle ? read_sel : (bus_en & drive_ok_ff);

    // Restart counter: loaded as busy rises, counts down while idle, then rests at zero.
    assign nxt_rearm = conv_end ? RW'(REARM_CYC) :
        ((idle && (rearm_ff != '0)) ? (rearm_ff - RW'(1)) : rearm_ff);

    // State sequence and conversion counter.
    always_comb begin
        // Hold state and count unless a branch below moves them.
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            // Acquiring: a start moves to hold and loads the conversion time.
            sca_pkg::SCA_ACQ: begin
                if (start_ok) begin
                    nxt_state = sca_pkg::SCA_CONV;
                    nxt_cnt = CNT_W'(CONV_CYC);
                end
            end
            // Converting: count down to the lead window.
            sca_pkg::SCA_CONV: begin
                nxt_cnt = cnt_ff - CNT_W'(1);
                if (lead_start) begin
                    nxt_state = sca_pkg::SCA_LEAD;
                end
            end
            // Lead: data is out; busy rises when the count ends.
            sca_pkg::SCA_LEAD: begin
                nxt_cnt = cnt_ff - CNT_W'(1);
                if (conv_end) begin
                    nxt_state = sca_pkg::SCA_ACQ;
                    nxt_cnt = '0;
                end
            end
            // Unused codes fall back to acquiring.
            default: begin
                nxt_state = sca_pkg::SCA_ACQ;
                nxt_cnt = '0;
            end
        endcase
    end

    // State, counter and edge memory.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= sca_pkg::SCA_ACQ;
            cnt_ff <= '0;
            req_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            req_ff <= start_lvl;
        end
    end

    // Hold switch and captured sample.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hold_ff <= 1'b0;
            held_ff <= 16'h0000;
        end else if (start_ok) begin
            hold_ff <= 1'b1;
            held_ff <= sample_in;
        end else if (conv_end) begin
            hold_ff <= 1'b0;
        end
    end

    // Busy and completion pulse.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_n_ff <= 1'b1;
            done_ff <= 1'b0;
        end else begin
            busy_n_ff <= ~(nxt_state != sca_pkg::SCA_ACQ);
            done_ff <= conv_end;
        end
    end

    // Deselect tracking: raising select during a conversion suppresses drive at the end.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            drive_ok_ff <= 1'b1;
        end else if (start_ok) begin
            drive_ok_ff <= 1'b1;
        end else if (!idle && deselect) begin
            drive_ok_ff <= 1'b0;
        end
    end

    // Result word and bus enable.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            result_ff <= 16'h0000;
            oe_ff <= 1'b0;
        end else begin
            if (lead_start) begin
                result_ff <= held_ff;
            end
            oe_ff <= nxt_oe;
        end
    end

    // Restart window register.
    // A start inside the window leaves it untouched; the next completion reloads it.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rearm_ff <= '0;
        end else begin
            rearm_ff <= nxt_rearm;
        end
    end

    // Outputs come straight from flip-flops.
    assign link.busy_n = busy_n_ff;
    assign link.result_bus = result_ff;
    assign link.result_oe = oe_ff;
endmodule

// >>> rtl/sca_host.sv
`include "sca_cfg.svh"

// Controller end: runs the recommended start/read sequence on request.
module sca_host #(
    parameter int unsigned SETUP_CYC = `SCA_SETUP_CYC,
    parameter int unsigned RAISE_CYC = `SCA_RAISE_CYC,
    parameter int unsigned SPACE_CYC = `SCA_SPACE_CYC
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic rst_n,
    // Link to the device.
    sca_link_if.host link,
    // User request and result.
    input wire logic start_req,
    output logic ready_ff,
    output logic data_valid_ff,
    output sca_pkg::sca_word_t data_ff
);
    localparam int unsigned CNT_W = $clog2(SPACE_CYC + 1);

    initial begin
        if (SETUP_CYC < 1 || RAISE_CYC < 1 || RAISE_CYC >= SPACE_CYC) begin
            $error("sca_host: timing counts out of range");
        end
    end

    sca_pkg::sca_host_e state_ff;
    sca_pkg::sca_host_e nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W-1:0] space_ff;
    logic cs_n_ff;
    logic rd_conv_ff;
    logic busy_d_ff;

    // Busy rising edge is the latch strobe for the result.
    wire busy_rise = link.busy_n & ~busy_d_ff;
    wire cnt_zero = (cnt_ff == '0);
    wire space_done = (space_ff == '0);

    // Sequence: convert low, then select low, raise read/convert early with select still low, then read at busy rise.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_zero ? cnt_ff : cnt_ff - CNT_W'(1);
        case (state_ff)
            sca_pkg::SCA_H_IDLE: begin
                if (start_req && space_done) begin
                    nxt_state = sca_pkg::SCA_H_SETUP;
                    nxt_cnt = CNT_W'(SETUP_CYC);
                end
            end
            sca_pkg::SCA_H_SETUP: begin
                if (cnt_zero) begin
                    nxt_state = sca_pkg::SCA_H_START;
                    nxt_cnt = CNT_W'(RAISE_CYC);
                end
            end
            sca_pkg::SCA_H_START: begin
                if (cnt_zero) begin
                    nxt_state = sca_pkg::SCA_H_WAIT;
                end
            end
            sca_pkg::SCA_H_WAIT: begin
                if (busy_rise) begin
                    nxt_state = sca_pkg::SCA_H_READ;
                end
            end
            sca_pkg::SCA_H_READ: begin
                nxt_state = sca_pkg::SCA_H_IDLE;
            end
            default: begin
                nxt_state = sca_pkg::SCA_H_IDLE;
            end
        endcase
    end

    // Select levels: read/convert stays high except in setup and start; select low to start and read.
    wire nxt_rd = !(nxt_state == sca_pkg::SCA_H_SETUP || nxt_state == sca_pkg::SCA_H_START);
    // Select goes low only at start; the read window uses read high with select low.
    wire nxt_cs = !(nxt_state == sca_pkg::SCA_H_START || nxt_state == sca_pkg::SCA_H_WAIT);

    // Sequencer registers and spacing counter.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= sca_pkg::SCA_H_IDLE;
            cnt_ff <= '0;
            space_ff <= '0;
            cs_n_ff <= 1'b1;
            rd_conv_ff <= 1'b1;
            busy_d_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            cs_n_ff <= nxt_cs;
            rd_conv_ff <= nxt_rd;
            busy_d_ff <= link.busy_n;
            if (state_ff == sca_pkg::SCA_H_SETUP && cnt_zero) begin
                space_ff <= CNT_W'(SPACE_CYC);
            end else if (!space_done) begin
                space_ff <= space_ff - CNT_W'(1);
            end
        end
    end

    // User-side result capture on the busy rising edge.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            data_ff <= 16'h0000;
            data_valid_ff <= 1'b0;
            ready_ff <= 1'b0;
        end else begin
            data_valid_ff <= 1'b0;
            if (state_ff == sca_pkg::SCA_H_WAIT && busy_rise) begin
                data_ff <= link.result_bus;
                data_valid_ff <= 1'b1;
            end
            ready_ff <= (nxt_state == sca_pkg::SCA_H_IDLE) && space_done;
        end
    end

    assign link.cs_n = cs_n_ff;
    assign link.rd_conv = rd_conv_ff;
endmodule

// >>> rtl/sca_link_if.sv
interface sca_link_if;
    // Active-low device select and read/convert select from the controller.
    logic cs_n;
    logic rd_conv;
    // Active-low busy and the result bus with its enable from the device.
    logic busy_n;
    sca_pkg::sca_word_t result_bus;
    logic result_oe;

    modport dev (input cs_n, input rd_conv, output busy_n, output result_bus, output result_oe);
    modport host (output cs_n, output rd_conv, input busy_n, input result_bus, input result_oe);
endinterface

// >>> rtl/sca_pkg.sv
package sca_pkg;
    // Result word width.
    localparam int unsigned RES_W = 16;
    typedef logic [RES_W-1:0] sca_word_t;
    // Device conversion states.
    typedef enum logic [1:0] {
        SCA_ACQ,
        SCA_CONV,
        SCA_LEAD
    } sca_dev_e;
    // Controller sequence states.
    typedef enum logic [2:0] {
        SCA_H_IDLE,
        SCA_H_SETUP,
        SCA_H_START,
        SCA_H_WAIT,
        SCA_H_READ,
        SCA_H_GAP
    } sca_host_e;
endpackage
